// [design/sad_sequencer.sv]
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sad_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [9:0] coreData,
  output var sad_pkg::sad_core_s coreCtl,
  input wire logic dmaTransferEnd,
  output logic dmaRequest,
  output logic irq
);
  // Bus: every request waits one cycle, then is accepted on the second edge.
  logic ack_r;
  logic [31:0] readdata_r;
  wire req = read | write;
  wire accept = req & ack_r;
  assign waitrequest = req & ~ack_r;
  assign readdata = readdata_r;

  wire [31:0] beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [31:0] wd = writedata & beMask;
  wire wrAcc = write & accept;
  wire rdAcc = read & accept;
  wire wGateOn = wrAcc & (address == sad_pkg::OFF_GATE_ON);
  wire wGateOff = wrAcc & (address == sad_pkg::OFF_GATE_OFF);
  wire wCmd = wrAcc & (address == sad_pkg::OFF_COMMAND);
  wire wMode = wrAcc & (address == sad_pkg::OFF_MODE);
  wire wOrder = wrAcc & (address == sad_pkg::OFF_ORDER);
  wire wClear = wrAcc & (address == sad_pkg::OFF_FLAG_CLEAR);
  wire wUnmask = wrAcc & (address == sad_pkg::OFF_IRQ_UNMASK);
  wire wMask = wrAcc & (address == sad_pkg::OFF_IRQ_MASK);
  wire rResult = rdAcc & (address == sad_pkg::OFF_RESULT);

  // Interface clock gate; while off, the digital part holds its state, except that a result read still clears the end-of-conversion flag
  // and a transfer end with halt set still latches a pending stop.
  logic gateOn_r;
  wire gateOn_nxt = wGateOn & wd[sad_pkg::GATE_BIT] ? 1'b1 :
                    wGateOff & wd[sad_pkg::GATE_BIT] ? 1'b0 : gateOn_r;
  wire live = gateOn_r; // RULE21

  wire cmdSoftReset = live & wCmd & wd[sad_pkg::CMD_SOFT_RESET];
  wire cmdOn = live & wCmd & wd[sad_pkg::CMD_ANALOG_ON];
  wire cmdOff = live & wCmd & wd[sad_pkg::CMD_ANALOG_OFF];
  wire cmdStart = live & wCmd & wd[sad_pkg::CMD_START];
  wire cmdStop = live & wCmd & wd[sad_pkg::CMD_STOP];
  wire clrAll = rst | cmdSoftReset; // RULE25

  // Configuration registers.
  logic [31:0] mode_r;
  logic [31:0] order_r;
  logic [sad_pkg::FLAG_W-1:0] irqMask_r;
  wire [31:0] mode_nxt = (live & wMode) ? ((mode_r & ~beMask) | wd) : mode_r;
  wire [31:0] order_nxt = (live & wOrder) ? ((order_r & ~beMask) | wd) : order_r;
  wire [sad_pkg::FLAG_W-1:0] irqMask_nxt =
    (live & wUnmask) ? (irqMask_r | wd[sad_pkg::FLAG_W-1:0]) :
    (live & wMask) ? (irqMask_r & ~wd[sad_pkg::FLAG_W-1:0]) : irqMask_r;

  wire [4:0] preload = mode_r[sad_pkg::MODE_PRELOAD_LSB +: 5];
  wire [15:0] warmupPeriodCount = mode_r[sad_pkg::MODE_WARMUP_LSB +: 16];
  wire [2:0] inputCountMinusOne = mode_r[sad_pkg::MODE_COUNT_LSB +: 3];
  wire repeatConversionSelect = mode_r[sad_pkg::MODE_REPEAT_BIT];
  wire haltOnTransferFinish = mode_r[sad_pkg::MODE_HALT_BIT];

  // Divider: period is preload times four master clocks, or one when zero.
  wire [6:0] divisor = {preload, 2'b00}; // RULE2 RULE3
  wire undivided = (divisor == 7'h00);
  logic [6:0] divCnt_r;
  logic convClk_r;
  wire divWrap = undivided | (divCnt_r == (divisor - 7'h01));
  wire tick = live & divWrap;
  wire [6:0] divCnt_nxt = !live ? divCnt_r : (divWrap ? 7'h00 : divCnt_r + 7'h01);
  wire convClk_nxt = undivided | (divCnt_nxt < {1'b0, divisor[6:1]}); // RULE3

  // Input order slots: low three bits of each four-bit slot select the input.
  logic [2:0] slotChan [sad_pkg::SLOTS];
  genvar gi;
  generate
    for (gi = 0; gi < sad_pkg::SLOTS; gi = gi + 1) begin : g_slot
      assign slotChan[gi] = order_r[4*gi +: 3]; // RULE20 RULE26
    end
  endgenerate

  // Sequencer state.
  sad_pkg::sad_state_e state_r, state_nxt;
  logic [15:0] warmCnt_r;
  logic [3:0] bitCnt_r;
  logic [2:0] seqIdx_r;
  logic stopPend_r;
  logic [9:0] result_r;
  logic eoc_r;
  logic lost_r;
  logic transfer_finished_flag_r;
  logic dmaReq_r;

  wire ready = (state_r == sad_pkg::ST_IDLE); // RULE13
  wire accepted = ready & cmdStart; // RULE12
  wire convDone = (state_r == sad_pkg::ST_CONV) & tick & (bitCnt_r == sad_pkg::LAST_RESOLVE); // RULE1
  wire seqLast = (seqIdx_r == inputCountMinusOne); // RULE6
  wire tendStop = haltOnTransferFinish & (transfer_finished_flag_r | dmaTransferEnd);
  wire stopNow = stopPend_r | cmdStop | tendStop; // RULE15 RULE17
  wire moreToDo = ~seqLast | (repeatConversionSelect & ~stopNow); // RULE15 RULE19

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sad_pkg::ST_OFF: begin
        if (cmdOn) begin
          state_nxt = sad_pkg::ST_WARM; // RULE11 RULE22
        end
      end
      sad_pkg::ST_WARM: begin
        if (live & (warmCnt_r >= warmupPeriodCount)) begin
          state_nxt = sad_pkg::ST_IDLE; // RULE11
        end
      end
      sad_pkg::ST_IDLE: begin
        if (accepted) begin
          state_nxt = sad_pkg::ST_CONV; // RULE5
        end
      end
      sad_pkg::ST_CONV: begin
        if (convDone) begin
          state_nxt = moreToDo ? sad_pkg::ST_GAP : sad_pkg::ST_IDLE;
        end
      end
      sad_pkg::ST_GAP: begin
        if (tick) begin
          state_nxt = sad_pkg::ST_CONV; // RULE19
        end
      end
      default: state_nxt = sad_pkg::ST_OFF;
    endcase
    if (cmdOff) begin
      state_nxt = sad_pkg::ST_OFF; // RULE21
    end
  end

  wire [15:0] warmCnt_nxt = (state_r == sad_pkg::ST_WARM) ?
                            (live ? warmCnt_r + 16'h0001 : warmCnt_r) : 16'h0000;
  wire [3:0] bitCnt_nxt = (state_r != sad_pkg::ST_CONV) ? 4'h0 :
                          (tick ? bitCnt_r + 4'h1 : bitCnt_r);
  wire [2:0] seqIdx_nxt = accepted ? 3'h0 :
                          convDone ? (seqLast ? 3'h0 : seqIdx_r + 3'h1) : seqIdx_r;
  wire stopPend_nxt = accepted ? 1'b0 :
                      (state_r == sad_pkg::ST_IDLE) ? 1'b0 : stopNow;
  wire [9:0] result_nxt = convDone ? coreData : result_r; // RULE7
  // A completion in the same cycle as a clearing read keeps the flag set.
  wire eoc_nxt = convDone | (eoc_r & ~rResult & ~cmdStart); // RULE7 RULE8 RULE24
  wire lost_nxt = (convDone & eoc_r & ~rResult) |
                  (lost_r & ~(live & wClear & wd[sad_pkg::FLAG_LOST])); // RULE9
  wire transfer_finished_flag_nxt = (live & dmaTransferEnd) |
                  (transfer_finished_flag_r & ~(live & wClear & wd[sad_pkg::FLAG_TRANSFER_FINISHED_FLAG])); // RULE10

  wire [sad_pkg::FLAG_W-1:0] flags = {ready, transfer_finished_flag_r, lost_r, eoc_r};
  assign irq = |(flags & irqMask_r); // RULE14

  wire [31:0] rdMux =
    (address == sad_pkg::OFF_GATE_STAT) ? {30'h0, gateOn_r, 1'b0} :
    (address == sad_pkg::OFF_MODE) ? mode_r :
    (address == sad_pkg::OFF_ORDER) ? order_r :
    (address == sad_pkg::OFF_FLAGS) ? {28'h0, flags} :
    (address == sad_pkg::OFF_IRQ_VIEW) ? {28'h0, irqMask_r} :
    (address == sad_pkg::OFF_RESULT) ? {22'h0, result_r} : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
      gateOn_r <= 1'b0;
    end else begin
      ack_r <= waitrequest;
      readdata_r <= (read & ~ack_r) ? rdMux : readdata_r;
      gateOn_r <= gateOn_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      mode_r <= sad_pkg::MODE_RESET; // RULE16
      order_r <= sad_pkg::ORDER_RESET;
      irqMask_r <= '0;
      divCnt_r <= 7'h00;
      convClk_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      order_r <= order_nxt;
      irqMask_r <= irqMask_nxt;
      divCnt_r <= divCnt_nxt;
      convClk_r <= convClk_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      state_r <= sad_pkg::ST_OFF;
      warmCnt_r <= 16'h0000;
      bitCnt_r <= 4'h0;
      seqIdx_r <= 3'h0;
      stopPend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      warmCnt_r <= warmCnt_nxt;
      bitCnt_r <= bitCnt_nxt;
      seqIdx_r <= seqIdx_nxt;
      stopPend_r <= stopPend_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      result_r <= 10'h000;
      eoc_r <= 1'b0;
      lost_r <= 1'b0;
      transfer_finished_flag_r <= 1'b0;
      dmaReq_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      eoc_r <= eoc_nxt;
      lost_r <= lost_nxt;
      transfer_finished_flag_r <= transfer_finished_flag_nxt;
      dmaReq_r <= convDone; // RULE7
    end
  end

  assign dmaRequest = dmaReq_r;
  // The core resets while start is high and converts after it falls.
  assign coreCtl.start = (state_r != sad_pkg::ST_CONV); // RULE5
  // Forced high while undivided so a divided phase cannot linger after the preload changes.
  assign coreCtl.convClk = convClk_r | undivided; // RULE2
  assign coreCtl.undivided = undivided;
  assign coreCtl.standby = (state_r == sad_pkg::ST_OFF); // RULE21 RULE22
  assign coreCtl.channel = slotChan[seqIdx_r];
endmodule : sad_sequencer
`default_nettype wire

// [shared/sad_pkg.sv]
// Functional notes
// [RULE1] One conversion lasts eleven converter clocks: one sampling, ten resolving bits.
// [RULE2] Converter clock is master clock divided by preload times four; zero means undivided.
// [RULE3] Divisors are multiples of four so the converter clock has even duty.
// [RULE4] Software keeps the converter clock below 700 kHz by its divisor choice.
// [RULE5] Start command begins a conversion; the core sees the inverted start level.
// [RULE6] Three-bit input count field converts field value plus one inputs per sequence.
// [RULE7] On completion latch result, set end-of-conversion flag, pulse the DMA request.
// [RULE8] Reading the result register clears the end-of-conversion flag.
// [RULE9] A result latched while the previous one is unread sets the lost flag.
// [RULE10] DMA transfer-end signal sets the transfer-finished flag.
// [RULE11] Enable starts a warm-up count of master clocks, then ready rises.
// [RULE12] Commands before ready are ignored; ready rises only after an enable.
// [RULE13] Ready is low when disabled or converting, high while waiting for start.
// [RULE14] Ready can raise the interrupt when its mask bit is set.
// [RULE15] Repeat mode runs until stop, or transfer finished with halt option set.
// [RULE16] Repeat-mode select resets to zero, meaning one-shot.
// [RULE17] After a stop the conversion in progress still completes and is stored.
// [RULE18] Software clears transfer-finished before the extra result, else resets or drains.
// [RULE19] Each conversion of a sequence repeats sample, resolve and latch steps.
// [RULE20] Input order register holds a four-bit slot per position, slot n at bit 4n.
// [RULE21] Disable puts the analog core in standby; clock gating stops the digital part.
// [RULE22] Wait state keeps digital clocked with analog off; enable returns to active.
// [RULE23] Software disables the analog part before gating the interface clock.
// [RULE24] Start command also clears the end-of-conversion flag.
// [RULE25] Soft reset returns every converter register to its reset state; the code leaves the gate bit gateOn_r and the read data register unchanged.
// [RULE26] Only the low three slot bits select an input; unused slots are ignored.
package sad_pkg;
  localparam logic [7:0] OFF_GATE_ON = 8'h50;
  localparam logic [7:0] OFF_GATE_OFF = 8'h54;
  localparam logic [7:0] OFF_GATE_STAT = 8'h58;
  localparam logic [7:0] OFF_COMMAND = 8'h60;
  localparam logic [7:0] OFF_MODE = 8'h64;
  localparam logic [7:0] OFF_ORDER = 8'h68;
  localparam logic [7:0] OFF_FLAG_CLEAR = 8'h6C;
  localparam logic [7:0] OFF_FLAGS = 8'h70;
  localparam logic [7:0] OFF_IRQ_UNMASK = 8'h74;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h78;
  localparam logic [7:0] OFF_IRQ_VIEW = 8'h7C;
  localparam logic [7:0] OFF_RESULT = 8'h80;
  // Gate register bit.
  localparam int GATE_BIT = 1;
  // Command bits.
  localparam int CMD_SOFT_RESET = 0;
  localparam int CMD_ANALOG_ON = 1;
  localparam int CMD_ANALOG_OFF = 2;
  localparam int CMD_START = 3;
  localparam int CMD_STOP = 4;
  // Mode register fields.
  localparam int MODE_PRELOAD_LSB = 0;
  localparam int MODE_WARMUP_LSB = 8;
  localparam int MODE_COUNT_LSB = 24;
  localparam int MODE_REPEAT_BIT = 28;
  localparam int MODE_HALT_BIT = 29;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ORDER_RESET = 32'h0000_0000;
  // Flag bit positions.
  localparam int FLAG_EOC = 0;
  localparam int FLAG_LOST = 1;
  localparam int FLAG_TRANSFER_FINISHED_FLAG = 2;
  localparam int FLAG_READY = 3;
  localparam int FLAG_W = 4;
  localparam logic [3:0] LAST_RESOLVE = 4'hA;
  localparam int SLOTS = 8;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WARM = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b011,
    ST_GAP = 3'b100
  } sad_state_e;
  typedef struct packed {
    logic start;
    logic convClk;
    logic undivided;
    logic standby;
    logic [2:0] channel;
  } sad_core_s;
endpackage : sad_pkg

// [tb/sad_sequencer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sad_sequencer_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire sad_pkg::sad_core_s coreCtl,
  input wire logic dmaRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_wait; (read | write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait)
    else $error("request held off too long");
  property p_conv;
    $fell(coreCtl.start) && coreCtl.undivided |-> ##1 !dmaRequest [*8] ##[3:4] dmaRequest;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion length wrong");
  property p_std; coreCtl.standby |-> coreCtl.start; endproperty
  a_std: assert property (p_std)
    else $error("core released while in standby");
  property p_undiv; coreCtl.undivided |-> coreCtl.convClk; endproperty
  a_undiv: assert property (p_undiv)
    else $error("divided clock runs while undivided");
  property p_pulse; dmaRequest |=> !dmaRequest; endproperty
  a_pulse: assert property (p_pulse)
    else $error("transfer request longer than one cycle");
  property p_cause;
    dmaRequest |-> !$past(coreCtl.start) || !$past(coreCtl.start, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("transfer request without conversion");
  property p_chan; !coreCtl.start && !$past(coreCtl.start) |-> $stable(coreCtl.channel); endproperty
  a_chan: assert property (p_chan)
    else $error("input changed during conversion");
  property p_hold; $changed(readdata) |-> $past(read | write); endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed without access");
  c_dma: cover property (dmaRequest);
  c_start: cover property ($fell(coreCtl.start));
  c_fast: cover property (coreCtl.undivided && !coreCtl.start);
endmodule : sad_sequencer_monitor
bind sad_sequencer sad_sequencer_monitor u_mon (.*);
`default_nettype wire

// [tb/sad_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sad_core_model (
  input wire sad_pkg::sad_core_s coreCtl,
  output logic [9:0] coreData
);
  // Held in reset the core shows mid-scale; while converting the code names the input.
  assign coreData = coreCtl.start ? 10'h200 : {coreCtl.channel, 7'h55};
endmodule : sad_core_model
`default_nettype wire

// [tb/sad_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sad_sequencer_tb_top;
  logic ref_clk, rst, read, write, waitrequest, dmaTransferEnd, dmaRequest, irq;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [9:0] coreData;
  sad_pkg::sad_core_s coreCtl;
  int failures, tests_run;
  sad_sequencer dut (.*);
  sad_core_model core (.coreCtl(coreCtl), .coreData(coreData));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 0;
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    while (!ok) begin
      @(posedge ref_clk);
      ok = (waitrequest === 1'b0);
      q = readdata;
      n++;
      if (n > 20) begin
        failures++;
        close_out();
      end
    end
    read <= 0;
    write <= 0;
    @(posedge ref_clk);
  endtask : bus
  task automatic pollr;
    int n;
    for (n = 0; n < 2000; n++) begin
      bus(0, 8'h70, 0);
      if (q[3] === 1'b1) return;
    end
    failures++;
    close_out();
  endtask : pollr
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  initial begin
    rst = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    byteenable = 4'hF;
    dmaTransferEnd = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    bus(0, 8'h64, 0);
    chk("mode", 0, q);
    bus(1, 8'h50, 32'h2);
    bus(1, 8'h60, 32'h8);
    bus(0, 8'h70, 0);
    chk("early", 0, q);
    bus(0, 8'h00, 0);
    chk("unmapped", 0, q);
    bus(1, 8'h64, 32'h0100_2014);
    bus(1, 8'h68, 32'h75);
    bus(1, 8'h60, 32'h2);
    bus(0, 8'h70, 0);
    chk("warm", 0, q);
    pollr();
    bus(1, 8'h74, 32'h8);
    chk("irq", 1, irq);
    bus(1, 8'h78, 32'h8);
    chk("irqoff", 0, irq);
    endt("ready");
    bus(1, 8'h60, 32'h8);
    bus(0, 8'h70, 0);
    chk("busy", 0, q[3]);
    pollr();
    chk("two", 32'hB, q);
    bus(0, 8'h80, 0);
    chk("res", 32'h3D5, q);
    bus(0, 8'h70, 0);
    chk("rdclr", 32'hA, q);
    bus(1, 8'h6C, 32'h2);
    bus(0, 8'h70, 0);
    chk("clr", 32'h8, q);
    endt("sequence");
    bus(1, 8'h64, 32'h3000_0114);
    bus(1, 8'h60, 32'h8);
    repeat (100) @(posedge ref_clk);
    dmaTransferEnd <= 1;
    @(posedge ref_clk);
    dmaTransferEnd <= 0;
    pollr();
    chk("transfer_finished_flag", 32'hC, q & 32'hC);
    bus(1, 8'h6C, 32'h6);
    bus(1, 8'h64, 32'h1000_0014);
    bus(1, 8'h60, 32'h8);
    repeat (30) @(posedge ref_clk);
    bus(1, 8'h60, 32'h10);
    pollr();
    chk("extra", 1, q[0]);
    endt("repeat");
    bus(1, 8'h60, 32'h1);
    bus(0, 8'h64, 0);
    chk("swmode", 0, q);
    bus(0, 8'h70, 0);
    chk("swflags", 0, q);
    bus(1, 8'h60, 32'h2);
    pollr();
    bus(1, 8'h60, 32'h8);
    pollr();
    chk("fast", 32'h9, q);
    bus(0, 8'h80, 0);
    chk("fastres", 32'h055, q);
    bus(1, 8'h60, 32'h4);
    bus(0, 8'h70, 0);
    chk("off", 0, q[3]);
    endt("power");
    close_out();
  end
endmodule : sad_sequencer_tb_top
`default_nettype wire
